// [rsl_pkg.sv]
// Package for the system reset source logic: register map, fields, timing
// Notes on behaviour
// - Each reset source owns a cause bit
// - Power-on sets power-on and low-voltage bits
// - Boot fetches SP at 0, PC at 4, LR ones
// - Peripherals disabled during reset, enabled when it ends
// - Debug clock pulled down, data pulled up
// - Reset pin open drain, wakes every mode
// - Option bit zero releases pin reset function
// - Pin filter uses oscillator or bus clock
// - Filters reset by power-on to negated pin
// - In stop, only oscillator filter or bypass
// - Deepest leakage stop disables and bypasses filter
// - Oscillator filter: count 3 plus 2 sync
// - Low-voltage detector off in VLP, LLS and VLLS; on in run, wait and stop
// - Low-voltage reset held until supply recovers
// - Low-voltage bit set on low-voltage or power-on
// - Watchdog timeout resets and sets its bit
// - Enabled wakeup inputs reset in the VLLS stop only
// - Wakeup flags kept until software clears
// - Clock monitor resets on lost reference
// - Lost reference sets loss-of-clock bit
package rsl_pkg;
    localparam logic [7:0]  ADR_CAUSE      = 8'h00;
    localparam logic [7:0]  ADR_FILT_CTRL  = 8'h04;
    localparam logic [7:0]  ADR_FILT_WIDTH = 8'h08;
    localparam logic [7:0]  ADR_LV_CTRL    = 8'h0c;
    localparam logic [7:0]  ADR_CLK_MON    = 8'h10;
    localparam logic [7:0]  ADR_WAKE_FLAGS = 8'h14;
    localparam logic [7:0]  ADR_MODE       = 8'h18;
    // Cause bit positions
    localparam int CB_WAKEUP = 0;
    localparam int CB_LVD    = 1;
    localparam int CB_LOC    = 2;
    localparam int CB_WATCHDOG_CAUSE_FLAG   = 5;
    localparam int CB_PIN    = 6;
    localparam int CB_POR    = 7;
    // Filter control fields
    localparam int FC_RUN_LSB  = 0;
    localparam int FC_STOP_POS = 2;
    localparam logic [1:0] FSEL_OFF = 2'h0;
    localparam logic [1:0] FSEL_BUS = 2'h1;
    localparam logic [1:0] FSEL_OSC = 2'h2;
    localparam int FW_BITS = 5;
    // Low-voltage and clock monitor control fields
    localparam int LV_RE_POS  = 4;
    localparam int LV_SEL_LSB = 0;
    localparam int CM_EN_POS  = 7;
    localparam int CM_RNG_POS = 4;
    // Reset values
    localparam logic [7:0] RST_LV_CTRL = 8'h10;
    localparam logic [7:0] RST_CLK_MON = 8'h00;
    // Timing
    localparam int SYS_CLK_HZ     = 100_000_000;
    localparam int OSC_HZ         = 1_000;
    localparam int OSC_DIV        = SYS_CLK_HZ / OSC_HZ;
    localparam int OSC_FILT_COUNT = 3;
    localparam int RESET_HOLD_CYC = 128;
    // Boot constants
    localparam logic [31:0] VEC_SP_OFFSET = 32'h0000_0000;
    localparam logic [31:0] VEC_PC_OFFSET = 32'h0000_0004;
    localparam logic [31:0] LINK_RESET    = 32'hffff_ffff;

    typedef enum logic [5:0] {
        PM_RUN  = 6'h01,
        PM_WAIT = 6'h02,
        PM_STOP = 6'h04,
        PM_VLP  = 6'h08,
        PM_LLS  = 6'h10,
        PM_VLLS = 6'h20
    } rsl_pmode_e;

    typedef struct packed {
        logic       por;
        logic       lv_below;
        logic       watchdog_cause_flag_timeout;
        logic       loc_event;
        logic [7:0] wake_in;
    } rsl_src_s;

    typedef struct packed {
        logic [31:0] sp_addr;
        logic [31:0] pc_addr;
        logic [31:0] link_init;
    } rsl_boot_s;
endpackage

// [rsl_reset_source.sv]
// System reset source logic with cause recording and reset pin filter
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
module rsl_reset_source #(
    parameter int WAKE_W  = 8,
    parameter int OSC_DIV = rsl_pkg::OSC_DIV
) (
    input  wire logic               CLK_SYS,
    input  wire logic               RESET_N,
    input  wire logic [7:0]         WB_ADR_I,
    input  wire logic [31:0]        WB_DAT_I,
    output logic [31:0]             WB_DAT_O,
    input  wire logic               WB_WE_I,
    input  wire logic [3:0]         WB_SEL_I,
    input  wire logic               WB_STB_I,
    input  wire logic               WB_CYC_I,
    output logic                    WB_ACK_O,
    input  wire rsl_pkg::rsl_src_s  SRC_I,
    input  wire logic               PIN_RESET_I,
    output logic                    PIN_RESET_O,
    output logic                    PIN_RESET_OE,
    input  wire logic               PIN_ENABLE_OPT,
    input  wire logic               CLK_MON_REF_OK,
    output logic                    SYS_RESET_N,
    output logic [2:0]              LV_THRESHOLD,
    output logic                    LV_DETECT_EN,
    output logic                    CLK_MON_EN,
    output logic                    CLK_MON_RANGE,
    output logic                    PERIPH_ENABLE,
    output logic                    SWD_CLK_PULLDOWN,
    output logic                    SWD_DIO_PULLUP,
    output rsl_pkg::rsl_boot_s      BOOT_O
);
    import rsl_pkg::*;

    if (WAKE_W < 1 || WAKE_W > 8) begin : g_wake_chk
        $error("WAKE_W must be 1..8");
    end
    if (OSC_DIV < 2) begin : g_div_chk
        $error("OSC_DIV must be at least 2");
    end

    logic [7:0] cause;
    logic [3:0] filt_ctrl;
    logic [FW_BITS-1:0] filt_width;
    logic [7:0] lv_ctrl;
    logic [7:0] clk_mon;
    logic [7:0] wake_flags;
    logic [5:0] mode;
    logic opt_done;
    logic opt_pin_en;

    // Two-flop synchronisers for pin, supply and monitor levels
    logic [2:0] sync1;
    logic [2:0] sync2;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1 <= 3'h5;
            sync2 <= 3'h5;
        end else begin
            sync1 <= {PIN_RESET_I, SRC_I.lv_below, CLK_MON_REF_OK};
            sync2 <= sync1;
        end
    end
    logic pin_s;
    logic lv_s;
    logic ref_ok_s;
    assign pin_s    = sync2[2];
    assign lv_s     = sync2[1];
    assign ref_ok_s = sync2[0];

    // Wakeup pins are asynchronous too, so they get the same two flops
    logic [7:0] wake_s1;
    logic [7:0] wake_s;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            wake_s1 <= 8'h00;
            wake_s  <= 8'h00;
        end else begin
            wake_s1 <= SRC_I.wake_in;
            wake_s  <= wake_s1;
        end
    end

    // Oscillator tick from divider
    logic [$clog2(OSC_DIV)-1:0] div_cnt;
    logic osc_tick;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) div_cnt <= '0;
        else if (osc_tick) div_cnt <= '0;
        else div_cnt <= div_cnt + 1'b1;
    end
    assign osc_tick = (div_cnt == $clog2(OSC_DIV)'(OSC_DIV - 1));

    // Pin option captured after release; zero drops the reset function
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            opt_done   <= 1'b0;
            opt_pin_en <= 1'b1;
        end else if (!opt_done) begin
            opt_done   <= 1'b1;
            opt_pin_en <= PIN_ENABLE_OPT;
        end
    end

    // Filter source select per mode
    logic in_stop;
    logic deepest;
    logic [1:0] fsel;
    assign in_stop = mode[2] | mode[3] | mode[4] | mode[5];
    assign deepest = mode[5] & (lv_ctrl[7:6] == 2'h0);
    always_comb begin
        if (deepest) fsel = FSEL_OFF;
        else if (in_stop) fsel = filt_ctrl[FC_STOP_POS] ? FSEL_OSC : FSEL_OFF;
        else fsel = filt_ctrl[FC_RUN_LSB +: 2];
    end

    // Filter: the filtered level starts negated (high)
    logic pin_filt;
    logic [FW_BITS-1:0] fcnt;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_filt <= 1'b1;
            fcnt     <= '0;
        end else if (fsel == FSEL_OFF || fsel == 2'h3) begin
            pin_filt <= pin_s;
            fcnt     <= '0;
        end else if (pin_s == pin_filt) begin
            fcnt <= '0;
        end else if (fsel == FSEL_BUS || osc_tick) begin
            if (fsel == FSEL_OSC && fcnt == FW_BITS'(OSC_FILT_COUNT - 1)) begin
                pin_filt <= pin_s;
                fcnt     <= '0;
            end else if (fsel == FSEL_BUS && fcnt >= filt_width) begin
                pin_filt <= pin_s;
                fcnt     <= '0;
            end else begin
                fcnt <= fcnt + 1'b1;
            end
        end
    end

    // Reset requests from each source
    logic lv_active;
    logic req_lv;
    logic req_pin;
    logic req_loc;
    logic req_wake;
    logic req_watchdog_cause_flag;
    logic pin_busy;
    assign lv_active = mode[0] | mode[1] | mode[2];
    assign req_lv    = lv_active & lv_ctrl[LV_RE_POS] & lv_s;
    // Own drive of the pin must not count as a new request, or reset never ends
    assign pin_busy  = opt_pin_en & ~pin_filt;
    assign req_pin   = pin_busy & ~in_reset;
    assign req_loc   = clk_mon[CM_EN_POS] & ~ref_ok_s;
    assign req_wake  = mode[5] & |wake_s[WAKE_W-1:0];
    assign req_watchdog_cause_flag  = SRC_I.watchdog_cause_flag_timeout;

    // Reset sequencer: hold 128 cycles and until lv recovers
    logic [7:0] hold_cnt;
    logic any_req;
    logic in_reset;
    assign any_req = req_lv | req_pin | req_loc | req_wake | req_watchdog_cause_flag;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            hold_cnt <= 8'(RESET_HOLD_CYC);
            in_reset <= 1'b1;
        end else if (any_req) begin
            hold_cnt <= 8'(RESET_HOLD_CYC);
            in_reset <= 1'b1;
        end else if (hold_cnt != 8'h00) begin
            hold_cnt <= hold_cnt - 1'b1;
        end else if (!pin_busy) begin
            in_reset <= 1'b0;
        end
    end

    // Cause register: latched at start of each reset event
    logic start_req;
    assign start_req = any_req & ~in_reset;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            cause <= 8'h82;
        end else if (start_req) begin
            cause <= 8'h00;
            cause[CB_LVD]    <= req_lv;
            cause[CB_PIN]    <= req_pin;
            cause[CB_LOC]    <= req_loc;
            cause[CB_WAKEUP] <= req_wake;
            cause[CB_WATCHDOG_CAUSE_FLAG]   <= req_watchdog_cause_flag;
        end
    end

    // Wakeup flags survive system reset, cleared by writing one
    logic wb_hit;
    logic wb_wr;
    assign wb_hit = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wb_wr  = wb_hit & WB_WE_I & WB_SEL_I[0];
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            wake_flags <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (i < WAKE_W && wake_s[i] && mode[5]) wake_flags[i] <= 1'b1;
                else if (wb_wr && WB_ADR_I == ADR_WAKE_FLAGS && WB_DAT_I[i])
                    wake_flags[i] <= 1'b0;
            end
        end
    end

    // Control registers; system reset returns only clk_mon and mode to defaults
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            filt_ctrl  <= 4'h0;
            filt_width <= '0;
            lv_ctrl    <= RST_LV_CTRL;
            clk_mon    <= RST_CLK_MON;
            mode       <= PM_RUN;
        end else if (start_req) begin
            clk_mon <= RST_CLK_MON;
            mode    <= PM_RUN;
        end else if (wb_wr) begin
            unique case (WB_ADR_I)
                ADR_FILT_CTRL:  filt_ctrl  <= WB_DAT_I[3:0];
                ADR_FILT_WIDTH: filt_width <= WB_DAT_I[FW_BITS-1:0];
                ADR_LV_CTRL:    lv_ctrl    <= WB_DAT_I[7:0];
                ADR_CLK_MON:    clk_mon    <= WB_DAT_I[7:0];
                ADR_MODE: begin
                    if ($onehot(WB_DAT_I[5:0])) mode <= WB_DAT_I[5:0];
                end
                default: ;
            endcase
        end
    end

    // Wishbone classic slave, one wait state, unmapped reads zero
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= wb_hit;
            if (wb_hit && !WB_WE_I) begin
                unique case (WB_ADR_I)
                    ADR_CAUSE:      WB_DAT_O <= {24'h0, cause};
                    ADR_FILT_CTRL:  WB_DAT_O <= {28'h0, filt_ctrl};
                    ADR_FILT_WIDTH: WB_DAT_O <= {27'h0, filt_width};
                    ADR_LV_CTRL:    WB_DAT_O <= {24'h0, lv_ctrl};
                    ADR_CLK_MON:    WB_DAT_O <= {24'h0, clk_mon};
                    ADR_WAKE_FLAGS: WB_DAT_O <= {24'h0, wake_flags};
                    ADR_MODE:       WB_DAT_O <= {26'h0, mode};
                    default:        WB_DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Pin driven low for the hold, then released; a low pin delays the end
    assign PIN_RESET_O      = 1'b0;
    assign PIN_RESET_OE     = in_reset & opt_pin_en & (hold_cnt != 8'h00);
    assign SYS_RESET_N      = ~in_reset;
    assign LV_THRESHOLD     = lv_ctrl[LV_SEL_LSB +: 3];
    assign LV_DETECT_EN     = lv_active;
    assign CLK_MON_EN       = clk_mon[CM_EN_POS];
    assign CLK_MON_RANGE    = clk_mon[CM_RNG_POS];
    assign PERIPH_ENABLE    = ~in_reset & opt_done;
    assign SWD_CLK_PULLDOWN = 1'b1;
    assign SWD_DIO_PULLUP   = 1'b1;
    assign BOOT_O           = '{VEC_SP_OFFSET, VEC_PC_OFFSET, LINK_RESET};

    property p_por_cause;
        @(posedge CLK_SYS) $rose(RESET_N) |-> (cause[CB_POR] && cause[CB_LVD]);
    endproperty
    a_por_cause: assert property (p_por_cause) else $error("por cause missing");

    property p_watchdog_cause_flag;
        @(posedge CLK_SYS) disable iff (!RESET_N)
            (req_watchdog_cause_flag && !in_reset) |=> (in_reset && cause[CB_WATCHDOG_CAUSE_FLAG]);
    endproperty
    a_watchdog_cause_flag: assert property (p_watchdog_cause_flag) else $error("watchdog reset missed");

    property p_loc;
        @(posedge CLK_SYS) disable iff (!RESET_N)
            (req_loc && !in_reset) |=> cause[CB_LOC];
    endproperty
    a_loc: assert property (p_loc) else $error("loc cause missing");

    property p_lv_hold;
        @(posedge CLK_SYS) disable iff (!RESET_N) req_lv |=> in_reset;
    endproperty
    a_lv_hold: assert property (p_lv_hold) else $error("lv reset not held");

    property p_lv_off;
        @(posedge CLK_SYS) disable iff (!RESET_N) (mode[3] || mode[4] || mode[5]) |-> !req_lv;
    endproperty
    a_lv_off: assert property (p_lv_off) else $error("lv active in low power");

    sequence s_osc_wait;
        fsel == FSEL_OSC && !osc_tick && pin_s != pin_filt;
    endsequence
    property p_deep_bypass;
        @(posedge CLK_SYS) disable iff (!RESET_N) deepest |=> (pin_filt == $past(pin_s));
    endproperty
    a_deep_bypass: assert property (p_deep_bypass) else $error("filter not bypassed");

    property p_filt_init;
        @(posedge CLK_SYS) $rose(RESET_N) |-> pin_filt;
    endproperty
    a_filt_init: assert property (p_filt_init) else $error("filter reset wrong");

    property p_hold_len;
        @(posedge CLK_SYS) disable iff (!RESET_N)
            $fell(in_reset) |-> $past(hold_cnt) == 8'h00;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset released early");

    property p_pin_wait;
        @(posedge CLK_SYS) disable iff (!RESET_N)
            (in_reset && !any_req && hold_cnt == 8'h00 && pin_busy) |=>
                (in_reset && !PIN_RESET_OE);
    endproperty
    a_pin_wait: assert property (p_pin_wait) else $error("reset ended with pin low");

    property p_osc_step;
        @(posedge CLK_SYS) disable iff (!RESET_N)
            s_osc_wait |=> $stable(pin_filt);
    endproperty
    a_osc_step: assert property (p_osc_step) else $error("osc filter moved off tick");
endmodule

// [rsl_far_model.sv]
// Far-side model: external reset pin with pull-up, supply and clock monitors
`timescale 1ns/100ps
module rsl_far_model (
    input  wire logic         clk,
    input  wire logic         pin_oe,
    output logic              pin_level,
    output rsl_pkg::rsl_src_s src,
    output logic              ref_ok
);
    import rsl_pkg::*;
    // Lines: 0 pin low, 1 supply low, 2 watchdog, 3 wakeup, 4 reference lost
    logic [4:0] act;
    int         left;
    initial begin
        act  = '0;
        left = 0;
    end
    // Open drain: pull-up wins unless someone pulls low
    assign pin_level = (pin_oe || act[0]) ? 1'b0 : 1'b1;
    assign src = '{por: 1'b0, lv_below: act[1], watchdog_cause_flag_timeout: act[2], loc_event: 1'b0,
                   wake_in: {7'h00, act[3]}};
    assign ref_ok = ~act[4];
    // Event lasts n cycles, so short or long stimuli come from one call
    always @(posedge clk) begin
        if (left == 1) begin
            act <= '0;
        end
        if (left > 0) begin
            left <= left - 1;
        end
    end
    task automatic fire(input int k, input int n);
        act[k] <= 1'b1;
        left   <= n;
    endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the system reset source logic
`timescale 1ns/100ps
module tb_top;
    import rsl_pkg::*;
    localparam int DIV = 4;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic        we = 1'b0;
    logic        stb = 1'b0;
    logic        cyc = 1'b0;
    logic        pin_opt = 1'b1;
    logic [31:0] dat_o, q;
    logic        ack, pin_lvl, pin_o, pin_oe, sys_n, ref_ok, lv_en, cm_en, cm_rng;
    logic        periph, swd_pd, swd_pu;
    logic [2:0]  lv_thr;
    rsl_src_s    src;
    rsl_boot_s   boot;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    always #5 clk_sys = ~clk_sys;

    rsl_reset_source #(.WAKE_W(8), .OSC_DIV(DIV)) u_dut (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .WB_ADR_I(adr), .WB_DAT_I(dat_i),
        .WB_DAT_O(dat_o), .WB_WE_I(we), .WB_SEL_I(4'hf), .WB_STB_I(stb), .WB_CYC_I(cyc),
        .WB_ACK_O(ack), .SRC_I(src), .PIN_RESET_I(pin_lvl), .PIN_RESET_O(pin_o),
        .PIN_RESET_OE(pin_oe), .PIN_ENABLE_OPT(pin_opt), .CLK_MON_REF_OK(ref_ok),
        .SYS_RESET_N(sys_n), .LV_THRESHOLD(lv_thr), .LV_DETECT_EN(lv_en),
        .CLK_MON_EN(cm_en), .CLK_MON_RANGE(cm_rng), .PERIPH_ENABLE(periph),
        .SWD_CLK_PULLDOWN(swd_pd), .SWD_DIO_PULLUP(swd_pu), .BOOT_O(boot));

    rsl_far_model u_far (.clk(clk_sys), .pin_oe(pin_oe), .pin_level(pin_lvl), .src(src),
        .ref_ok(ref_ok));

    task automatic print_verdict();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Classic single cycle; the wait has no fixed length
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        adr   <= a;
        we    <= w;
        dat_i <= d;
        cyc   <= 1'b1;
        stb   <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            $display("BAD %0t no bus answer", $time);
        end
        @(posedge clk_sys);
    endtask

    task automatic wait_sys(input logic v, input int lim, input string what);
        int n;
        n = 0;
        while (sys_n !== v && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        check(sys_n, v, what);
    endtask

    task automatic hold_sys(input logic v, input int n, input string what);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            @(posedge clk_sys);
            ok = ok & (sys_n === v);
        end
        check(ok, 1'b1, what);
    endtask

    // One reset round trip, then the recorded cause
    task automatic sys_cycle(input logic [31:0] cause, input string what);
        wait_sys(1'b0, 60, what);
        wait_sys(1'b1, 600, what);
        wb(ADR_CAUSE, 1'b0, 32'h0);
        check(q, cause, what);
    endtask

    task automatic t_during();
        check(sys_n, 1'b0, "held in por");
        check(periph, 1'b0, "periph off");
        check(pin_oe, 1'b1, "pin driven in reset");
        check({swd_pd, swd_pu}, 2'b11, "swd pulls");
        check(boot.sp_addr, 32'h0000_0000, "sp vector");
        check(boot.pc_addr, 32'h0000_0004, "pc vector");
        check(boot.link_init, 32'hffff_ffff, "link value");
    endtask

    task automatic t_por();
        wait_sys(1'b1, 400, "por release");
        wb(ADR_CAUSE, 1'b0, 32'h0);
        check(q, 32'h0000_0082, "por cause");
        wb(ADR_LV_CTRL, 1'b0, 32'h0);
        check(q, 32'h0000_0010, "lv ctrl reset");
        wb(ADR_CLK_MON, 1'b0, 32'h0);
        check(q, 32'h0000_0000, "clk mon reset");
        wb(8'h1c, 1'b0, 32'h0);
        check(q, 32'h0000_0000, "unmapped read");
        check({lv_en, cm_en, pin_o}, 3'b100, "monitor outs");
        check({periph, pin_oe}, 2'b10, "running outs");
    endtask

    task automatic t_loc();
        wb(ADR_LV_CTRL, 1'b1, 32'h15);
        check(lv_thr, 3'h5, "threshold out");
        wb(ADR_CLK_MON, 1'b1, 32'h90);
        check({cm_en, cm_rng}, 2'b11, "monitor on");
        u_far.fire(4, 20);
        sys_cycle(32'h0000_0004, "loc cause");
        u_far.fire(2, 1);
        sys_cycle(32'h0000_0020, "watchdog_cause_flag cause");
    endtask

    task automatic t_lvd();
        wb(ADR_LV_CTRL, 1'b1, 32'h00);
        u_far.fire(1, 30);
        hold_sys(1'b1, 40, "lv reset off");
        wb(ADR_LV_CTRL, 1'b1, 32'h10);
        u_far.fire(1, 300);
        wait_sys(1'b0, 20, "lv reset");
        hold_sys(1'b0, 250, "lv held");
        wait_sys(1'b1, 400, "lv recover");
        wb(ADR_CAUSE, 1'b0, 32'h0);
        check(q, 32'h0000_0002, "lv cause");
    endtask

    task automatic t_modes();
        wb(ADR_CLK_MON, 1'b1, 32'h00);
        for (int i = 0; i < 6; i++) begin
            wb(ADR_MODE, 1'b1, 32'h1 << i);
            check(lv_en, i < 3, "detector by mode");
        end
        wb(ADR_MODE, 1'b1, 32'h03);
        wb(ADR_MODE, 1'b0, 32'h0);
        check(q, 32'h0000_0020, "bad mode ignored");
        wb(ADR_MODE, 1'b1, 32'h01);
    endtask

    task automatic t_wake();
        wb(ADR_MODE, 1'b1, 32'h20);
        u_far.fire(3, 4);
        sys_cycle(32'h0000_0001, "wake cause");
        wb(ADR_WAKE_FLAGS, 1'b0, 32'h0);
        check(q, 32'h0000_0001, "wake flag kept");
        wb(ADR_WAKE_FLAGS, 1'b1, 32'h01);
        wb(ADR_WAKE_FLAGS, 1'b0, 32'h0);
        check(q, 32'h0000_0000, "wake flag cleared");
    endtask

    task automatic t_pin();
        wb(ADR_FILT_CTRL, 1'b1, {30'h0, FSEL_OSC});
        u_far.fire(0, 2 * DIV);
        hold_sys(1'b1, 15 * DIV, "short pulse filtered");
        u_far.fire(0, 10 * DIV);
        sys_cycle(32'h0000_0040, "pin cause");
        wb(ADR_FILT_CTRL, 1'b1, {30'h0, FSEL_OSC});
        wb(ADR_MODE, 1'b1, 32'h20);
        u_far.fire(0, 3);
        sys_cycle(32'h0000_0040, "deepest stop bypass");
    endtask

    // Bus-clock filter in run, then oscillator filter chosen for stop
    task automatic t_filters();
        wb(ADR_FILT_WIDTH, 1'b1, 32'h04);
        wb(ADR_FILT_CTRL, 1'b1, {30'h0, FSEL_BUS});
        u_far.fire(0, 3);
        hold_sys(1'b1, 20, "bus filter short");
        u_far.fire(0, 20);
        sys_cycle(32'h0000_0040, "bus filter pin");
        wb(ADR_FILT_CTRL, 1'b1, 32'h04);
        wb(ADR_MODE, 1'b1, 32'h04);
        u_far.fire(0, 2 * DIV);
        hold_sys(1'b1, 15 * DIV, "stop osc short");
        u_far.fire(0, 10 * DIV);
        sys_cycle(32'h0000_0040, "stop osc pin");
    endtask

    // Second power-on with the pin option cleared
    task automatic t_pin_opt();
        pin_opt <= 1'b0;
        reset_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        wait_sys(1'b1, 400, "second por");
        wb(ADR_CAUSE, 1'b0, 32'h0);
        check(q, 32'h0000_0082, "no pin cause");
        check(pin_oe, 1'b0, "pin not driven");
        u_far.fire(0, 40);
        hold_sys(1'b1, 100, "pin released");
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("BAD %0t run too long", $time);
            print_verdict();
        end
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        t_during();
        reset_n <= 1'b1;
        t_por();
        t_loc();
        t_lvd();
        t_modes();
        t_wake();
        t_pin();
        t_filters();
        t_pin_opt();
        print_verdict();
    end
endmodule
